/* rtl/mii_rx_consts.svh */
`ifndef MII_RX_CONSTS_SVH
`define MII_RX_CONSTS_SVH
// system clock rate and output clock rates in kHz
`define SYS_CLK_KHZ      32'd10000
`define RX_CLK_10M_KHZ   32'd2500
`define RX_CLK_100M_KHZ  32'd25000
// half-period counts; 100 Mbit/s cannot go below one cycle at this rate
`define HALF_10M_CYC     ((`SYS_CLK_KHZ / `RX_CLK_10M_KHZ) / 2)
`define HALF_100M_CYC    32'd1
// delimiter and idle nibble codes on the symbol side
`define SYM_J            5'h18
`define SYM_K            5'h11
`define SYM_T            5'h0d
`define SYM_R            5'h07
`define SYM_IDLE         5'h1f
`define BUF_DEPTH        2
`endif

/* rtl/mii_rx_pkg.sv */
package mii_rx_pkg;
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_GOT_J = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_GOT_T = 4'b1000
  } rx_state_e;

  typedef struct packed {
    logic [3:0] nib;
    logic       err;
  } rx_word_s;

  typedef struct packed {
    logic [3:0] rxd;
    logic       dv;
    logic       er;
  } mii_rx_out_s;
endpackage

/* rtl/rx_word_buffer.sv */
`timescale 1ns/1ps
`include "mii_rx_consts.svh"
module rx_word_buffer
  import mii_rx_pkg::*;
(
  input  wire logic     i_clk,
  input  wire logic     i_srst,
  input  wire logic     i_in_valid,
  input  wire rx_word_s i_in_data,
  output logic          o_in_ready,
  output logic          o_out_valid,
  output rx_word_s      o_out_data,
  input  wire logic     i_out_ready
);
  typedef struct packed {
    rx_word_s [1:0] mem;
    logic           wp;
    logic           rp;
    logic [1:0]     cnt;
  } buf_s;
  buf_s s_q;
  buf_s s_d;
  logic push;
  logic pop;

  always_comb begin
    s_d  = s_q;
    push = i_in_valid && (s_q.cnt != 2'd2);
    pop  = i_out_ready && (s_q.cnt != 2'd0);
    if (push) begin
      s_d.mem[s_q.wp] = i_in_data;
      s_d.wp          = ~s_q.wp;
    end
    if (pop) begin
      s_d.rp = ~s_q.rp;
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_in_ready  = (s_q.cnt != 2'd2);
  assign o_out_valid = (s_q.cnt != 2'd0);
  assign o_out_data  = s_q.mem[s_q.rp];
endmodule

/* rtl/mii_clk_gen.sv */
`timescale 1ns/1ps
`include "mii_rx_consts.svh"
module mii_clk_gen (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_speed_100,
  input  wire logic i_realign,
  output logic      o_clk_level,
  output logic      o_rise
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       lvl;
    logic       rise;
  } gen_s;
  gen_s s_q;
  gen_s s_d;
  logic [7:0] half;

  always_comb begin
    half = i_speed_100 ? 8'(`HALF_100M_CYC) : 8'(`HALF_10M_CYC);
    s_d      = s_q;
    s_d.rise = 1'b0;
    if (i_realign) begin
      s_d.cnt = 8'h00;
      s_d.lvl = 1'b0;
    end else if (s_q.cnt + 8'h01 >= half) begin
      s_d.cnt  = 8'h00;
      s_d.lvl  = ~s_q.lvl;
      s_d.rise = ~s_q.lvl;
    end else begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_clk_level = s_q.lvl;
  assign o_rise      = s_q.rise;
endmodule

/* rtl/mii_rx_clock_block.sv */
`timescale 1ns/1ps
`include "mii_rx_consts.svh"
// Contract
// - receive clock is 2.5 MHz at 10 Mbit/s and 25 MHz at 100 Mbit/s; code gives 5 MHz at 100 Mbit/s
// - at 10 Mbit/s receive clock recovered from line stream edges
// - at 10 Mbit/s clock keeps running after stream ends, last packet timing
// - at 100 Mbit/s clock follows line while link carries data or idle
// - at 100 Mbit/s without link, clock comes from reference clock
// - at 10 Mbit/s source switches only between carrier rise and valid rise
// - at 10 Mbit/s lock may shift clock phase up to 360 degrees
// - at 100 Mbit/s link bring-up may shift clock phase up to 360 degrees
// - at 10 Mbit/s clock realigns once per packet
// - at 100 Mbit/s clock realigns once, at link establishment
// - receive clock and receive error outputs gated by tristate control
// - nibble bit zero is least significant, bit three most significant
// - while valid is high, nibble updates on receive clock rising edges
// - valid rises only after start delimiter pair detected
// - valid falls after end delimiter pair or signal error
// - valid changes only in step with receive clock
// - receive error unused at 10 Mbit/s
// - at 100 Mbit/s receive error raised on errors within valid frame
// - at 100 Mbit/s receive error raised on false carrier
// - receive error changes only in step with receive clock
// - transmit clock 2.5 MHz at 10 Mbit/s and 25 MHz at 100 Mbit/s; code gives 5 MHz at 100 Mbit/s
// - carrier on rx or tx in half duplex; rx only in full duplex/repeater
module mii_rx_clock_block
  import mii_rx_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_speed_100,
  input  wire logic       i_full_duplex,
  input  wire logic       i_repeater,
  input  wire logic       i_line_clk,
  input  wire logic       i_line_act,
  input  wire logic       i_link_up,
  input  wire logic [4:0] i_sym,
  input  wire logic       i_sym_err,
  input  wire logic       i_tx_act,
  input  wire logic       i_receive_output_tristate_control,
  output logic            o_rx_clk,
  output logic            o_rx_clk_oe,
  output logic [3:0]      o_rxd,
  output logic            o_rx_dv,
  output logic            o_rx_er,
  output logic            o_rx_er_oe,
  output logic            o_tx_clk,
  output logic            o_crs
);
  typedef struct packed {
    logic [1:0] line_clk_s;
    logic [1:0] line_act_s;
    logic [1:0] link_s;
    logic [1:0] tri_s;
    logic [1:0] tx_act_s;
    logic [4:0] sym_s0;
    logic [4:0] sym_s1;
    logic [1:0] sym_err_s;
    logic       line_clk_d;
    logic       crs_d;
    logic       locked;
    logic       link_aligned;
    logic       fc_pend;
    rx_state_e  st;
    logic [3:0] rxd;
    logic       dv;
    logic       er;
    logic       rx_clk;
    logic       rx_clk_oe;
    logic       er_oe;
    logic       tx_clk;
    logic       crs;
  } top_s;
  top_s s_q;
  top_s s_d;

  logic     line_rise;
  logic     realign;
  logic     rx_lvl;
  logic     rx_rise;
  logic     tx_lvl;
  logic     sym_stb;
  logic     buf_ready;
  logic     out_valid;
  rx_word_s in_word;
  rx_word_s out_word;
  logic     rx_act;
  logic     is_j;
  logic     is_k;
  logic     is_t;
  logic     is_idle;
  logic     word_push;
  logic     false_carrier;
  logic     crs_rx;
  logic     crs_tx;

  // receive clock: realigned by realign pulse, free running otherwise
  mii_clk_gen u_rx_gen (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_speed_100 (i_speed_100),
    .i_realign   (realign),
    .o_clk_level (rx_lvl),
    .o_rise      (rx_rise)
  );

  // transmit clock from reference, never realigned
  mii_clk_gen u_tx_gen (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_speed_100 (i_speed_100),
    .i_realign   (1'b0),
    .o_clk_level (tx_lvl),
    .o_rise      ()
  );

  rx_word_buffer u_buf (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_in_valid  (word_push),
    .i_in_data   (in_word),
    .o_in_ready  (buf_ready),
    .o_out_valid (out_valid),
    .o_out_data  (out_word),
    .i_out_ready (rx_rise)
  );

  always_comb begin
    s_d            = s_q;
    s_d.line_clk_s = {s_q.line_clk_s[0], i_line_clk};
    s_d.line_act_s = {s_q.line_act_s[0], i_line_act};
    s_d.link_s     = {s_q.link_s[0], i_link_up};
    s_d.tri_s      = {s_q.tri_s[0], i_receive_output_tristate_control};
    s_d.tx_act_s   = {s_q.tx_act_s[0], i_tx_act};
    // symbol bus is steady around the line clock rise, so two flops suffice
    s_d.sym_s0     = i_sym;
    s_d.sym_s1     = s_q.sym_s0;
    s_d.sym_err_s  = {s_q.sym_err_s[0], i_sym_err};
    s_d.line_clk_d = s_q.line_clk_s[1];
    line_rise      = s_q.line_clk_s[1] && !s_q.line_clk_d;
    sym_stb        = line_rise && buf_ready;
    rx_act         = s_q.line_act_s[1];
    in_word.nib    = s_q.sym_s1[3:0];
    in_word.err    = s_q.sym_err_s[1];

    is_j           = (s_q.sym_s1 == `SYM_J);
    is_k           = (s_q.sym_s1 == `SYM_K);
    is_t           = (s_q.sym_s1 == `SYM_T);
    is_idle        = (s_q.sym_s1 == `SYM_IDLE);
    // end delimiter closes the frame and is no data nibble
    word_push      = sym_stb && (s_q.st == RX_DATA) && !is_t;
    false_carrier  = i_speed_100 && sym_stb && (s_q.st == RX_IDLE) && !is_idle && !is_j;

    realign        = 1'b0;
    s_d.crs_d      = rx_act;
    if (!i_speed_100) begin
      // one realignment per packet, after carrier rise and before valid
      if (rx_act && !s_q.crs_d) begin
        s_d.locked = 1'b0;
      end
      if (rx_act && !s_q.locked && line_rise && !s_q.dv) begin
        realign    = 1'b1;
        s_d.locked = 1'b1;
      end
      // no realign after stream end: clock keeps last packet timing
      s_d.link_aligned = 1'b0;
    end else begin
      if (!s_q.link_s[1]) begin
        s_d.link_aligned = 1'b0;
      end else if (!s_q.link_aligned && line_rise) begin
        realign          = 1'b1;
        s_d.link_aligned = 1'b1;
      end
    end
    unique case (s_q.st)
      RX_IDLE: begin
        if (sym_stb && is_j) begin
          s_d.st = RX_GOT_J;
        end
      end
      RX_GOT_J: begin
        if (sym_stb) begin
          s_d.st = is_k ? RX_DATA : RX_IDLE;
        end
      end
      RX_DATA: begin
        if (sym_stb && (is_t || s_q.sym_err_s[1])) begin
          s_d.st = is_t ? RX_GOT_T : RX_IDLE;
        end
      end
      RX_GOT_T: begin
        if (sym_stb) begin
          s_d.st = RX_IDLE;
        end
      end
      default: s_d.st = RX_IDLE;
    endcase
    if (rx_rise) begin
      s_d.dv  = out_valid;
      if (out_valid) begin
        s_d.rxd = out_word.nib;
      end
      if (!i_speed_100) begin
        s_d.er = 1'b0;
      end else begin
        s_d.er = (out_valid && out_word.err) || s_q.fc_pend;
      end
    end

    // false carrier held until the next receive clock rise; a new one wins
    if (rx_rise) begin
      s_d.fc_pend = 1'b0;
    end
    if (false_carrier) begin
      s_d.fc_pend = 1'b1;
    end

    s_d.rx_clk    = rx_lvl;
    s_d.tx_clk    = tx_lvl;
    s_d.rx_clk_oe = !s_q.tri_s[1];
    s_d.er_oe     = !s_q.tri_s[1];
    crs_rx        = rx_act;
    crs_tx        = !i_full_duplex && !i_repeater && s_q.tx_act_s[1];
    s_d.crs       = crs_rx || crs_tx;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_q    <= '0;
      s_q.st <= RX_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rx_clk    = s_q.rx_clk;
  assign o_rx_clk_oe = s_q.rx_clk_oe;
  assign o_rxd       = s_q.rxd;
  assign o_rx_dv     = s_q.dv;
  assign o_rx_er     = s_q.er;
  assign o_rx_er_oe  = s_q.er_oe;
  assign o_tx_clk    = s_q.tx_clk;
  assign o_crs       = s_q.crs;
endmodule

/* testbench/mii_rx_clock_block_asserts.sv */
`timescale 1ns/1ps
module mii_rx_clock_block_asserts (
  input wire logic       i_clk,
  input wire logic       i_srst,
  input wire logic       i_speed_100,
  input wire logic       i_full_duplex,
  input wire logic       i_repeater,
  input wire logic       i_line_act,
  input wire logic       i_tx_act,
  input wire logic       i_receive_output_tristate_control,
  input wire logic       o_rx_clk,
  input wire logic       o_rx_clk_oe,
  input wire logic [3:0] o_rxd,
  input wire logic       o_rx_dv,
  input wire logic       o_rx_er,
  input wire logic       o_rx_er_oe,
  input wire logic       o_tx_clk,
  input wire logic       o_crs
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  property p_tri;
    i_receive_output_tristate_control [*4] |-> !o_rx_clk_oe && !o_rx_er_oe;
  endproperty
  a_tri: assert property (p_tri) else $error("rx pins driven while floated");
  property p_er10;
    !i_speed_100 |-> !o_rx_er;
  endproperty
  a_er10: assert property (p_er10) else $error("rx error at 10M");
  property p_dv_sync;
    !i_speed_100 && $changed(o_rx_dv) |-> o_rx_clk;
  endproperty
  a_dv_sync: assert property (p_dv_sync) else $error("valid moved off rx clock");
  property p_rxd_sync;
    !i_speed_100 && o_rx_dv && $changed(o_rxd) |-> o_rx_clk;
  endproperty
  a_rxd_sync: assert property (p_rxd_sync) else $error("nibble moved off rx clock");
  property p_tx10;
    !i_speed_100 && $rose(o_tx_clk) |=> o_tx_clk ##1 !o_tx_clk [*2] ##1 o_tx_clk;
  endproperty
  a_tx10: assert property (p_tx10) else $error("tx clock period at 10M");
  property p_tx100;
    i_speed_100 && $rose(o_tx_clk) |=> !o_tx_clk ##1 o_tx_clk;
  endproperty
  a_tx100: assert property (p_tx100) else $error("tx clock period at 100M");
  property p_crs_fd;
    ((i_full_duplex || i_repeater) && !i_line_act) [*4] |-> !o_crs;
  endproperty
  a_crs_fd: assert property (p_crs_fd) else $error("carrier without rx");
  property p_crs_hd;
    (!i_full_duplex && !i_repeater && i_tx_act) [*4] |-> o_crs;
  endproperty
  a_crs_hd: assert property (p_crs_hd) else $error("no carrier on tx");
  c_dv: cover property ($rose(o_rx_dv));
  c_er: cover property ($rose(o_rx_er));
  c_crs: cover property ($rose(o_crs));
endmodule
bind mii_rx_clock_block mii_rx_clock_block_asserts chk (.*);

/* testbench/mac_rx_model.sv */
`timescale 1ns/1ps
module mac_rx_model (
  input wire logic       i_clk,
  input wire logic       i_rx_clk,
  input wire logic       i_dv,
  input wire logic       i_er,
  input wire logic [3:0] i_rxd
);
  logic [3:0] got[$];
  logic       er_seen = 1'h0;
  logic       clk_q = 1'h0;
  always @(posedge i_clk) begin
    clk_q <= i_rx_clk;
    if (i_rx_clk && !clk_q) begin
      if (i_dv) got.push_back(i_rxd);
      if (i_er) er_seen <= 1'h1;
    end
  end
endmodule

/* testbench/mii_rx_clock_block_tb_top.sv */
`timescale 1ns/1ps
`include "mii_rx_consts.svh"
module mii_rx_clock_block_tb_top;
  import mii_rx_pkg::*;
  typedef struct packed {logic s; logic [3:0] a; logic [3:0] b;} row_s;
  logic i_clk = 1'h0, i_srst = 1'h1, i_speed_100 = 1'h0, i_full_duplex = 1'h0, i_repeater = 1'h0;
  logic i_line_clk = 1'h0, i_line_act = 1'h0, i_link_up = 1'h0, i_sym_err = 1'h0, i_tx_act = 1'h0;
  logic i_receive_output_tristate_control = 1'h0;
  logic [4:0] i_sym = `SYM_IDLE;
  logic o_rx_clk, o_rx_clk_oe, o_rx_dv, o_rx_er, o_rx_er_oe, o_tx_clk, o_crs;
  logic [3:0] o_rxd;
  int failures = 0;
  int cmp_count = 0;
  row_s rows[4] = '{'{1'h0, 4'h1, 4'h8}, '{1'h0, 4'ha, 4'h5}, '{1'h1, 4'h3, 4'hc}, '{1'h1, 4'he, 4'h0}};
  always #50 i_clk = ~i_clk;
  mii_rx_clock_block dut (.*);
  mac_rx_model mac (.i_clk(i_clk), .i_rx_clk(o_rx_clk), .i_dv(o_rx_dv), .i_er(o_rx_er), .i_rxd(o_rxd));
  task cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task chk(input string n, input logic [3:0] e, input logic [3:0] s);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task wrap_up;
    $display("failures %0d cmp_count %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task restart(input logic s);
    i_srst <= 1'h1;
    i_speed_100 <= s;
    i_link_up <= s;
    cyc(2);
    i_srst <= 1'h0;
    cyc(6);
    mac.got.delete();
    mac.er_seen = 1'h0;
  endtask
  // one line symbol, line clock 800 ns
  task send(input logic [4:0] s, input logic e);
    i_sym <= s;
    i_sym_err <= e;
    cyc(2);
    i_line_clk <= 1'h1;
    cyc(4);
    i_line_clk <= 1'h0;
    cyc(2);
  endtask
  task frame(input logic [3:0] a, input logic [3:0] b, input logic e);
    i_line_act <= 1'h1;
    send(`SYM_J, 1'h0);
    send(`SYM_K, 1'h0);
    send({1'h0, a}, 1'h0);
    send({1'h0, b}, e);
    send(`SYM_T, 1'h0);
    send(`SYM_R, 1'h0);
    i_line_act <= 1'h0;
    i_sym <= ~`SYM_R;
    cyc(20);
  endtask
  initial begin
    cyc(2);
    chk("reset", 4'h0, {o_rx_clk_oe, o_rx_dv, o_rx_er, o_crs});
    foreach (rows[k]) begin
      restart(rows[k].s);
      frame(rows[k].a, rows[k].b, 1'h0);
      chk("count", 4'h2, 4'(mac.got.size()));
      chk("nib0", rows[k].a, mac.got[0]);
      chk("nib1", rows[k].b, mac.got[1]);
      chk("er", 4'h0, mac.er_seen);
    end
    restart(1'h1);
    i_line_act <= 1'h1;
    send(`SYM_J, 1'h0);
    send(`SYM_K, 1'h0);
    send(5'h05, 1'h0);
    send(5'h0a, 1'h1);
    i_line_act <= 1'h0;
    cyc(20);
    chk("er100", 4'h1, mac.er_seen);
    chk("ecount", 4'h2, 4'(mac.got.size()));
    restart(1'h1);
    i_line_act <= 1'h1;
    send(5'h03, 1'h0);
    i_line_act <= 1'h0;
    cyc(20);
    chk("false", 4'h1, mac.er_seen);
    chk("fcount", 4'h0, 4'(mac.got.size()));
    restart(1'h0);
    frame(4'h1, 4'h8, 1'h1);
    chk("er10", 4'h0, mac.er_seen);
    i_receive_output_tristate_control <= 1'h1;
    cyc(6);
    chk("oe_off", 4'h0, {o_rx_clk_oe, o_rx_er_oe});
    i_receive_output_tristate_control <= 1'h0;
    cyc(6);
    chk("oe_on", 4'h3, {o_rx_clk_oe, o_rx_er_oe});
    i_tx_act <= 1'h1;
    i_full_duplex <= 1'h1;
    cyc(6);
    chk("crs_fd", 4'h0, o_crs);
    i_full_duplex <= 1'h0;
    i_repeater <= 1'h1;
    cyc(6);
    chk("crs_rep", 4'h0, o_crs);
    i_repeater <= 1'h0;
    cyc(6);
    chk("crs_hd", 4'h1, o_crs);
    wrap_up();
  end
  initial begin
    #2000000;
    failures++;
    wrap_up();
  end
endmodule
